// ==== rtl/dfp_pkg.sv ====
// Constants, register map and carrier types for the drive fault protection block.
// Assumes a 250 MHz controller clock and an APB master with 32-bit data.
//
// Contract
// - Fan action trip (0) and fan error block output and flag fan fault.
// - Fan action warning (1) asserts outputs with function 8 on fan error.
// - Overheat blocks output even in fan warning mode.
// - DC link below trip threshold stops output and flags low voltage.
// - Nonzero judgement delay blocks at once, declares fault after delay.
// - Undervoltage warning output ignores the judgement delay.
// - Output-block input (function 5) on during run blocks output, shows indication.
// - Monitoring values stay available while output is blocked by input.
// - Output-block input off with run still present resumes acceleration.
// - Keypad reset key or reset input (function 3) clears fault state.
// - Option card link error or removal during run is option fault.
// - Option action 1 blocks output; action 2 decelerates with trip time.
// - Run command with motor disconnected leads to no-motor trip.
// - Current below level for configured time raises no-motor trip.
// - Low voltage during run reported as separate major fault.
// - Separate warnings for overload, underload, inverter overload, fan, braking, tuning.
package dfp_pkg;
    localparam int unsigned CLK_MHZ = 250;
    localparam int unsigned TICK_US = 100000;
    localparam int unsigned TICK_CYC_FULL = TICK_US * CLK_MHZ;
    localparam logic [24:0] TICK_CYC = 25'(TICK_CYC_FULL - 1);
    localparam logic [11:0] ADDR_CTRL = 12'h000;
    localparam logic [11:0] ADDR_FUNC = 12'h004;
    localparam logic [11:0] ADDR_NOMOTOR = 12'h008;
    localparam logic [11:0] ADDR_FAULT = 12'h00C;
    localparam logic [11:0] ADDR_WARN = 12'h010;
    localparam logic [11:0] ADDR_IRQ_STAT = 12'h014;
    localparam logic [11:0] ADDR_IRQ_MASK = 12'h018;
    localparam logic [3:0] FAN_TRIP = 4'h0;
    localparam logic [3:0] FAN_WARN = 4'h1;
    localparam logic [1:0] OPT_NONE = 2'h0;
    localparam logic [1:0] OPT_FREE = 2'h1;
    localparam logic [1:0] OPT_DEC = 2'h2;
    localparam logic [7:0] OUT_FN_FAN = 8'h08;
    localparam logic [7:0] OUT_FN_LV = 8'h0B;
    localparam logic [3:0] IN_FN_RST = 4'h3;
    localparam logic [3:0] IN_FN_BLOCK = 4'h5;
    localparam logic [9:0] LV_DELAY_RST = 10'h000;
    localparam logic [9:0] LV_DELAY_MAX = 10'h258;
    localparam logic [6:0] NM_LEVEL_RST = 7'h05;
    localparam logic [6:0] NM_LEVEL_MIN = 7'h01;
    localparam logic [6:0] NM_LEVEL_MAX = 7'h64;
    localparam logic [6:0] NM_TIME_RST = 7'h1E;
    localparam logic [6:0] NM_TIME_MIN = 7'h01;
    localparam logic [6:0] NM_TIME_MAX = 7'h64;
    localparam int unsigned FAULT_N = 11;
    localparam int unsigned WARN_N = 8;
    localparam int unsigned EVENT_N = 19;
    localparam int F_FAN = 0;
    localparam int F_HEAT = 1;
    localparam int F_OPT = 2;
    localparam int F_NOMOTOR = 3;
    localparam int F_LV2 = 4;
    localparam int F_WDOG = 5;
    localparam int F_MEM = 6;
    localparam int F_LV = 7;
    localparam int F_BLOCK = 8;
    localparam int F_CMDLOSS = 9;
    localparam int F_SAFETY = 10;
    localparam int W_OL = 0;
    localparam int W_UL = 1;
    localparam int W_IOL = 2;
    localparam int W_FAN = 3;
    localparam int W_DB = 4;
    localparam int W_TUNE = 5;
    localparam int W_LV = 6;
    localparam int W_CMDLOSS = 7;
    localparam logic [FAULT_N-1:0] LATCH_MASK = 11'h07F;

    typedef struct packed {
        logic fan_err;
        logic overheat;
        logic dc_low;
        logic opt_link_err;
        logic opt_present;
        logic wdog_timeout;
        logic mem_err;
        logic cmd_loss;
        logic safety_open;
    } dfp_sense_t;

    typedef struct packed {
        logic overload;
        logic underload;
        logic inv_overload;
        logic db_rate;
        logic tune_err;
    } dfp_warn_src_t;

    typedef struct packed {
        logic [7:0] relay_fn;
        logic [7:0] q1_fn;
        logic [3:0] in_fn;
    } dfp_func_t;

    typedef struct packed {
        logic block;
        logic decel;
        logic run_enable;
        logic monitor_valid;
        logic relay;
        logic q1;
    } dfp_drive_t;
endpackage : dfp_pkg

// ==== rtl/dfp_qual_timer.sv ====
// Delay qualifier: counts ticks while a condition holds and flags expiry.
// Assumes a tick strobe from the same clock; the counter restarts when the condition drops.
`timescale 1ns/1ps
`default_nettype none
module dfp_qual_timer (
    input wire logic ref_clk_i,
    input wire logic nrst_i,
    input wire logic tick_i,
    input wire logic cond_i,
    input wire logic [9:0] limit_i,
    output logic expired_o
);
    import dfp_pkg::*;

    typedef struct packed {
        logic [9:0] count;
        logic done;
    } dfp_qual_state_t;

    dfp_qual_state_t state_reg;
    dfp_qual_state_t state_next;

    always_comb begin
        state_next = state_reg;
        if (!cond_i) begin
            state_next.count = 10'h000;
            state_next.done = 1'b0;
        end else if (state_reg.count >= limit_i) begin
            state_next.done = 1'b1;
        end else if (tick_i) begin
            state_next.count = state_reg.count + 10'h001;
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (!nrst_i) begin
            state_reg <= '0;
        end else begin
            state_reg <= state_next;
        end
    end

    assign expired_o = state_reg.done;
endmodule // dfp_qual_timer
`default_nettype wire

// ==== rtl/dfp_protect.sv ====
// Drive fault protection supervisor with APB register access and one interrupt.
// Assumes sense pins and terminal inputs are asynchronous and are synchronised here.
`timescale 1ns/1ps
`default_nettype none
module dfp_protect (
    input wire logic ref_clk_i,
    input wire logic nrst_i,
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [11:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    output logic [31:0] prdata_o,
    output logic pready_o,
    output logic pslverr_o,
    input wire dfp_pkg::dfp_sense_t sense_i,
    input wire dfp_pkg::dfp_warn_src_t warn_src_i,
    input wire logic run_cmd_i,
    input wire logic terminal_i,
    input wire logic keypad_reset_i,
    input wire logic [6:0] current_pct_i,
    output dfp_pkg::dfp_drive_t drive_o,
    output logic [10:0] fault_o,
    output logic [7:0] warn_o,
    output logic irq_o
);
    import dfp_pkg::*;

    typedef struct packed {
        dfp_sense_t sense_s1;
        dfp_sense_t sense_s2;
        dfp_warn_src_t warn_s1;
        dfp_warn_src_t warn_s2;
        logic [2:0] run_s1;
        logic [2:0] run_s2;
        logic running;
        logic rst_prev;
        logic [24:0] tick_cnt;
        logic tick;
        logic [3:0] fan_mode;
        logic [1:0] opt_mode;
        logic [9:0] lv_delay;
        dfp_func_t func;
        logic [6:0] nm_level;
        logic [6:0] nm_time;
        logic [FAULT_N-1:0] fault;
        logic [WARN_N-1:0] warn;
        logic [EVENT_N-1:0] irq_stat;
        logic [EVENT_N-1:0] irq_mask;
        logic [31:0] rdata;
        dfp_drive_t drive;
    } dfp_state_t;

    dfp_state_t state_reg;
    dfp_state_t state_next;
    logic lv_expired;
    logic nm_expired;
    logic nm_cond;
    logic [9:0] nm_limit;

    function automatic logic [6:0] clamp7(input logic [6:0] v, input logic [6:0] lo,
                                          input logic [6:0] hi);
        clamp7 = (v < lo) ? lo : ((v > hi) ? hi : v);
    endfunction

    function automatic logic out_assigned(input dfp_func_t f, input logic [7:0] fn);
        out_assigned = (f.relay_fn == fn) || (f.q1_fn == fn);
    endfunction

    assign nm_cond = state_reg.running && (current_pct_i < state_reg.nm_level);
    assign nm_limit = {3'h0, state_reg.nm_time};

    dfp_qual_timer u_lv_timer (
        .ref_clk_i(ref_clk_i),
        .nrst_i(nrst_i),
        .tick_i(state_reg.tick),
        .cond_i(state_reg.sense_s2.dc_low),
        .limit_i(state_reg.lv_delay),
        .expired_o(lv_expired)
    );

    dfp_qual_timer u_nm_timer (
        .ref_clk_i(ref_clk_i),
        .nrst_i(nrst_i),
        .tick_i(state_reg.tick),
        .cond_i(nm_cond),
        .limit_i(nm_limit),
        .expired_o(nm_expired)
    );

    always_comb begin
        logic [FAULT_N-1:0] fset;
        logic [WARN_N-1:0] wnow;
        logic [EVENT_N-1:0] evt;
        logic [EVENT_N-1:0] wclr;
        logic blk_in;
        logic rst_in;
        logic do_reset;
        logic wr;
        logic rd;
        logic dc_low;
        fset = '0;
        wnow = '0;
        evt = '0;
        wclr = '0;
        state_next = state_reg;
        state_next.sense_s1 = sense_i;
        state_next.sense_s2 = state_reg.sense_s1;
        state_next.warn_s1 = warn_src_i;
        state_next.warn_s2 = state_reg.warn_s1;
        state_next.run_s1 = {run_cmd_i, terminal_i, keypad_reset_i};
        state_next.run_s2 = state_reg.run_s1;
        state_next.running = state_reg.run_s2[2];
        blk_in = state_reg.run_s2[1] && (state_reg.func.in_fn == IN_FN_BLOCK);
        rst_in = state_reg.run_s2[1] && (state_reg.func.in_fn == IN_FN_RST);
        state_next.rst_prev = rst_in || state_reg.run_s2[0];
        do_reset = (rst_in || state_reg.run_s2[0]) && !state_reg.rst_prev;
        dc_low = state_reg.sense_s2.dc_low;
        wr = psel_i && penable_i && pwrite_i;
        rd = psel_i && !penable_i && !pwrite_i;
        if (state_reg.tick_cnt == TICK_CYC) begin
            state_next.tick_cnt = '0;
            state_next.tick = 1'b1;
        end else begin
            state_next.tick_cnt = state_reg.tick_cnt + 25'h0000001;
            state_next.tick = 1'b0;
        end
        // Latched causes.
        fset[F_FAN] = state_reg.sense_s2.fan_err && (state_reg.fan_mode == FAN_TRIP);
        fset[F_HEAT] = state_reg.sense_s2.overheat;
        fset[F_OPT] = (state_reg.sense_s2.opt_link_err
                       || (state_reg.running && !state_reg.sense_s2.opt_present))
                      && (state_reg.opt_mode != OPT_NONE);
        fset[F_NOMOTOR] = nm_expired;
        fset[F_LV2] = dc_low && state_reg.running && lv_expired;
        fset[F_WDOG] = state_reg.sense_s2.wdog_timeout;
        fset[F_MEM] = state_reg.sense_s2.mem_err;
        // Level causes follow their source directly.
        fset[F_LV] = lv_expired;
        fset[F_BLOCK] = blk_in && state_reg.running;
        fset[F_CMDLOSS] = state_reg.sense_s2.cmd_loss;
        fset[F_SAFETY] = state_reg.sense_s2.safety_open;
        for (int i = 0; i < FAULT_N; i++) begin
            if (LATCH_MASK[i]) begin
                state_next.fault[i] = fset[i] || (state_reg.fault[i] && !do_reset);
            end else begin
                state_next.fault[i] = fset[i];
            end
        end
        wnow[W_OL] = state_reg.warn_s2.overload;
        wnow[W_UL] = state_reg.warn_s2.underload;
        wnow[W_IOL] = state_reg.warn_s2.inv_overload;
        wnow[W_FAN] = state_reg.sense_s2.fan_err && (state_reg.fan_mode == FAN_WARN);
        wnow[W_DB] = state_reg.warn_s2.db_rate;
        wnow[W_TUNE] = state_reg.warn_s2.tune_err;
        wnow[W_LV] = dc_low;
        wnow[W_CMDLOSS] = state_reg.sense_s2.cmd_loss;
        state_next.warn = wnow;
        // Output block: undervoltage blocks at once, before the delay declares the fault.
        state_next.drive.block = (|(state_next.fault & ~(11'h1 << F_OPT))) || dc_low
                                 || (state_next.fault[F_OPT] && state_reg.opt_mode == OPT_FREE);
        state_next.drive.decel = state_next.fault[F_OPT] && (state_reg.opt_mode == OPT_DEC);
        // Dropping the block input while the run command stays lets the ramp restart.
        state_next.drive.run_enable = state_reg.running && !state_next.drive.block
                                      && !state_next.drive.decel;
        state_next.drive.monitor_valid = 1'b1;
        state_next.drive.relay = (out_assigned(state_reg.func, OUT_FN_FAN)
                                  && state_reg.func.relay_fn == OUT_FN_FAN && wnow[W_FAN])
                                 || (state_reg.func.relay_fn == OUT_FN_LV && dc_low);
        state_next.drive.q1 = (state_reg.func.q1_fn == OUT_FN_FAN && wnow[W_FAN])
                              || (state_reg.func.q1_fn == OUT_FN_LV && dc_low);
        evt = {wnow & ~state_reg.warn, state_next.fault & ~state_reg.fault};
        if (wr && paddr_i == ADDR_IRQ_STAT) begin
            wclr = pwdata_i[EVENT_N-1:0];
        end
        // A new event in the clearing cycle wins over the clear.
        state_next.irq_stat = evt | (state_reg.irq_stat & ~wclr);
        if (wr) begin
            case (paddr_i)
                ADDR_CTRL: begin
                    state_next.fan_mode = pwdata_i[3:0];
                    state_next.opt_mode = pwdata_i[5:4];
                    state_next.lv_delay = (pwdata_i[17:8] > LV_DELAY_MAX) ? LV_DELAY_MAX
                                          : pwdata_i[17:8];
                end
                ADDR_FUNC: begin
                    state_next.func = pwdata_i[19:0];
                end
                ADDR_NOMOTOR: begin
                    state_next.nm_level = clamp7(pwdata_i[6:0], NM_LEVEL_MIN, NM_LEVEL_MAX);
                    state_next.nm_time = clamp7(pwdata_i[14:8], NM_TIME_MIN, NM_TIME_MAX);
                end
                ADDR_IRQ_MASK: begin
                    state_next.irq_mask = pwdata_i[EVENT_N-1:0];
                end
                default: begin
                end
            endcase
        end
        if (rd) begin
            case (paddr_i)
                ADDR_CTRL: state_next.rdata = {14'h0, state_reg.lv_delay, 2'h0,
                                               state_reg.opt_mode, state_reg.fan_mode};
                ADDR_FUNC: state_next.rdata = {12'h0, state_reg.func};
                ADDR_NOMOTOR: state_next.rdata = {17'h0, state_reg.nm_time, 1'b0,
                                                  state_reg.nm_level};
                ADDR_FAULT: state_next.rdata = {21'h0, state_reg.fault};
                ADDR_WARN: state_next.rdata = {24'h0, state_reg.warn};
                ADDR_IRQ_STAT: state_next.rdata = {13'h0, state_reg.irq_stat};
                ADDR_IRQ_MASK: state_next.rdata = {13'h0, state_reg.irq_mask};
                default: state_next.rdata = 32'h00000000;
            endcase
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (!nrst_i) begin
            state_reg <= '0;
            state_reg.fan_mode <= FAN_TRIP;
            state_reg.lv_delay <= LV_DELAY_RST;
            state_reg.nm_level <= NM_LEVEL_RST;
            state_reg.nm_time <= NM_TIME_RST;
        end else begin
            state_reg <= state_next;
        end
    end

    // Read data is loaded in the setup cycle, so the access phase needs no wait state.
    assign pready_o = psel_i && penable_i;
    assign pslverr_o = psel_i && penable_i && (paddr_i[1:0] != 2'h0 || paddr_i > ADDR_IRQ_MASK);
    assign prdata_o = state_reg.rdata;
    assign drive_o = state_reg.drive;
    assign fault_o = state_reg.fault;
    assign warn_o = state_reg.warn;
    assign irq_o = |(state_reg.irq_stat & state_reg.irq_mask);

    a_fan_trip_block: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
        state_reg.fault[F_FAN] |-> state_reg.drive.block)
        else $error("Fan fault without output block.");
    a_heat_blocks: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
        state_reg.sense_s2.overheat |=> state_reg.drive.block)
        else $error("Overheat did not block output.");
    a_lv_immediate: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
        state_reg.sense_s2.dc_low |=> state_reg.drive.block && state_reg.warn[W_LV])
        else $error("Undervoltage did not block or warn at once.");
    a_latch_holds: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
        state_reg.fault[F_WDOG] && !state_reg.run_s2[0] && !state_reg.run_s2[1]
        |=> state_reg.fault[F_WDOG])
        else $error("Latched fault cleared without reset.");
    a_opt_decel: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
        state_reg.drive.decel |-> $past(state_reg.opt_mode) == OPT_DEC
                                  && !state_reg.drive.run_enable)
        else $error("Deceleration without option decel mode.");
    a_block_level: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
        $fell(state_reg.run_s2[1]) && state_reg.func.in_fn == IN_FN_BLOCK
        |=> !state_reg.fault[F_BLOCK])
        else $error("Block indication outlived its input.");
    a_monitor_kept: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
        state_reg.fault[F_BLOCK] |-> state_reg.drive.monitor_valid)
        else $error("Monitoring lost during output block.");
    a_irq_event_set: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
        state_reg.fault[F_FAN] && !$past(state_reg.fault[F_FAN]) |-> state_reg.irq_stat[F_FAN])
        else $error("Rising fan fault did not set its interrupt status.");
endmodule // dfp_protect
`default_nettype wire

// ==== testbench/dfp_drive_model.sv ====
// Power stage partner: registers the sense levels asked for by the bench and models current.
// Assumes a motor is connected, so current flows only while the drive runs unblocked.
`timescale 1ns/1ps
`default_nettype none
module dfp_drive_model (
    input wire logic ref_clk_i,
    input wire logic nrst_i,
    input wire dfp_pkg::dfp_drive_t drive_i,
    input wire dfp_pkg::dfp_sense_t sense_req_i,
    input wire dfp_pkg::dfp_warn_src_t warn_req_i,
    output dfp_pkg::dfp_sense_t sense_o,
    output dfp_pkg::dfp_warn_src_t warn_src_o,
    output logic [6:0] current_pct_o
);
    import dfp_pkg::*;
    // Current stays above the no-motor level while the drive runs unblocked, and is zero while blocked, even with the run command held.
    always_ff @(posedge ref_clk_i) begin
        sense_o <= sense_req_i;
        warn_src_o <= warn_req_i;
        current_pct_o <= (nrst_i && drive_i.run_enable && !drive_i.block) ? 7'h32 : 7'h00;
    end
endmodule // dfp_drive_model
`default_nettype wire

// ==== testbench/testbench.sv ====
// Self-checking bench for the fault protection block: APB tasks and scripted sense changes.
// Assumes faults settle within six edges of a sense change; APB answers are awaited, not timed.
`timescale 1ns/1ps
`default_nettype none
module testbench;
    import dfp_pkg::*;
    logic clk = 1'b0, nrst = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic pready, pslverr, irq, err, run_cmd = 1'b0, terminal = 1'b0, keypad = 1'b0;
    logic [6:0] cur;
    logic [10:0] fault;
    logic [7:0] warn;
    dfp_sense_t sreq = '0, sns;
    dfp_warn_src_t wreq = '0, wsrc;
    dfp_drive_t drv;
    int miscompares = 0, samples_checked = 0;
    always #2 clk = ~clk;
    dfp_protect DUT (.ref_clk_i(clk), .nrst_i(nrst), .psel_i(psel), .penable_i(penable),
        .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata),
        .pready_o(pready), .pslverr_o(pslverr), .sense_i(sns), .warn_src_i(wsrc),
        .run_cmd_i(run_cmd), .terminal_i(terminal), .keypad_reset_i(keypad),
        .current_pct_i(cur), .drive_o(drv), .fault_o(fault), .warn_o(warn), .irq_o(irq));
    dfp_drive_model partner (.ref_clk_i(clk), .nrst_i(nrst), .drive_i(drv), .sense_req_i(sreq),
        .warn_req_i(wreq), .sense_o(sns), .warn_src_o(wsrc), .current_pct_o(cur));
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", samples_checked, miscompares);
        if (miscompares == 0 && samples_checked > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            $display("unexpected at %0t: saw %h, wanted %h", $time, seen, exp);
            miscompares++;
        end
    endtask
    // The request is held until pready is sampled high at a rising edge.
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        @(posedge clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        for (n = 0; n < 16; n++) begin
            @(posedge clk);
            if (pready === 1'b1) break;
        end
        if (n == 16) begin
            miscompares++;
            wrap_up();
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic settle();
        repeat (6) @(posedge clk);
        #1;
    endtask
    task automatic reset_key();
        @(posedge clk);
        keypad <= 1'b1;
        settle();
        @(posedge clk);
        keypad <= 1'b0;
        settle();
    endtask
    initial begin
        repeat (50000) @(posedge clk);
        miscompares++;
        wrap_up();
    end
    initial begin
        sreq.opt_present = 1'b1;
        repeat (5) @(posedge clk);
        nrst <= 1'b1;
        run_cmd <= 1'b1;
        settle();
        check({fault, warn, 11'h0, irq, drv.block}, 32'h0);
        apb(1'b0, ADDR_CTRL, 32'h0);
        check(rd, 32'h0);
        apb(1'b0, 12'h01C, 32'h0);
        check({rd[30:0], err}, 32'h1);
        apb(1'b1, ADDR_FAULT, 32'h7FF);
        apb(1'b0, ADDR_FAULT, 32'h0);
        check(rd, 32'h0);
        apb(1'b1, ADDR_IRQ_MASK, 32'h7FFFF);
        @(posedge clk);
        sreq.fan_err <= 1'b1;
        settle();
        check({fault, irq, drv.block}, {11'h001, 2'b11});
        @(posedge clk);
        sreq.fan_err <= 1'b0;
        settle();
        apb(1'b0, ADDR_FAULT, 32'h0);
        check(rd, 32'h1);
        reset_key();
        check({fault, drv.block}, 12'h0);
        apb(1'b0, ADDR_IRQ_STAT, 32'h0);
        check(rd[0], 1'b1);
        apb(1'b1, ADDR_IRQ_STAT, 32'h7FFFF);
        #1;
        check(irq, 1'b0);
        apb(1'b1, ADDR_CTRL, {28'h0, FAN_WARN});
        apb(1'b1, ADDR_FUNC, {20'h0, OUT_FN_FAN, 4'h0});
        @(posedge clk);
        sreq.fan_err <= 1'b1;
        settle();
        check({fault, warn, drv.q1, drv.block}, {11'h0, 8'h08, 2'b10});
        @(posedge clk);
        sreq.overheat <= 1'b1;
        settle();
        check({fault, drv.block}, {11'h002, 1'b1});
        @(posedge clk);
        sreq.overheat <= 1'b0;
        sreq.fan_err <= 1'b0;
        apb(1'b1, ADDR_FUNC, {20'h0, OUT_FN_FAN, IN_FN_RST});
        @(posedge clk);
        terminal <= 1'b1;
        settle();
        check({fault, drv.block}, 12'h0);
        @(posedge clk);
        terminal <= 1'b0;
        apb(1'b1, ADDR_CTRL, 32'h0);
        apb(1'b1, ADDR_FUNC, {12'h0, OUT_FN_LV, OUT_FN_LV, 4'h0});
        @(posedge clk);
        sreq.dc_low <= 1'b1;
        settle();
        check({fault, drv.block, drv.q1, drv.relay}, {11'h090, 3'b111});
        @(posedge clk);
        sreq.dc_low <= 1'b0;
        settle();
        check({fault, drv.block}, {11'h010, 1'b1});
        reset_key();
        apb(1'b1, ADDR_CTRL, 32'h100);
        @(posedge clk);
        sreq.dc_low <= 1'b1;
        settle();
        check({fault, drv.block}, 12'h001);
        check(drv.q1, 1'b1);
        @(posedge clk);
        sreq.dc_low <= 1'b0;
        apb(1'b1, ADDR_FUNC, {28'h0, IN_FN_BLOCK});
        @(posedge clk);
        terminal <= 1'b1;
        settle();
        check({fault, drv.block}, {11'h100, 1'b1});
        check(drv.monitor_valid, 1'b1);
        @(posedge clk);
        terminal <= 1'b0;
        settle();
        check({fault, drv.block, drv.run_enable}, {11'h0, 2'b01});
        apb(1'b1, ADDR_CTRL, {26'h0, OPT_FREE, 4'h0});
        @(posedge clk);
        sreq.opt_link_err <= 1'b1;
        settle();
        check({fault, drv.block}, {11'h004, 1'b1});
        @(posedge clk);
        sreq.opt_link_err <= 1'b0;
        reset_key();
        apb(1'b1, ADDR_CTRL, {26'h0, OPT_DEC, 4'h0});
        @(posedge clk);
        sreq.opt_present <= 1'b0;
        settle();
        check({fault[F_OPT], drv.decel}, 2'b11);
        @(posedge clk);
        sreq.opt_present <= 1'b1;
        sreq.wdog_timeout <= 1'b1;
        sreq.mem_err <= 1'b1;
        reset_key();
        check(fault, 11'h060);
        @(posedge clk);
        sreq.wdog_timeout <= 1'b0;
        sreq.mem_err <= 1'b0;
        wreq <= '1;
        sreq.cmd_loss <= 1'b1;
        sreq.safety_open <= 1'b1;
        reset_key();
        check({fault, warn, drv.block}, {11'h600, 8'hB7, 1'b1});
        @(posedge clk);
        wreq <= '0;
        sreq.cmd_loss <= 1'b0;
        sreq.safety_open <= 1'b0;
        settle();
        check({fault, warn, drv.block}, 20'h0);
        apb(1'b1, ADDR_IRQ_STAT, 32'h7FFFF);
        #1;
        check({warn, irq}, 9'h0);
        wrap_up();
    end
endmodule // testbench
`default_nettype wire
